// >>> logic/ddq_pkg.sv
// package: constants, types and helpers for the strobe-based double-rate datapath
package ddq_pkg;

  localparam int DQ_W = 36;
  localparam int EDGE_STROBES = 18;
  localparam int CODE_W = 8;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;
  localparam logic [DQ_W-1:0] LANES_X4 = 36'h0_0000_000f;
  localparam logic [DQ_W-1:0] LANES_X8 = 36'h0_0000_00ff;
  localparam logic [DQ_W-1:0] LANES_X9 = 36'h0_0000_01ff;
  localparam logic [DQ_W-1:0] LANES_X16 = 36'h0_0000_ffff;
  localparam logic [DQ_W-1:0] LANES_X18 = 36'h0_0003_ffff;
  localparam logic [DQ_W-1:0] LANES_X32 = 36'h0_ffff_ffff;
  localparam logic [DQ_W-1:0] LANES_X36 = 36'hf_ffff_ffff;

  typedef enum logic [1:0] {
    DDQ_X4 = 2'h0,
    DDQ_X8 = 2'h1,
    DDQ_X16 = 2'h2,
    DDQ_X32 = 2'h3
  } ddq_width_t;

  typedef enum logic [1:0] {
    DDQ_SEEK = 2'h1,
    DDQ_MEAS = 2'h2
  } ddq_phase_st_t;

  // active data lanes of a strobe group
  function automatic logic [DQ_W-1:0] ddq_lanes(input ddq_width_t w, input logic par);
    logic [DQ_W-1:0] m;
    m = LANES_X4;
    case (w)
      DDQ_X4: begin
        m = LANES_X4;
      end
      DDQ_X8: begin
        m = par ? LANES_X9 : LANES_X8;
      end
      DDQ_X16: begin
        m = par ? LANES_X18 : LANES_X16;
      end
      DDQ_X32: begin
        m = par ? LANES_X36 : LANES_X32;
      end
      default: begin
        m = LANES_X4;
      end
    endcase
    return m;
  endfunction

endpackage

// >>> logic/ddq_phase_if.sv
// interface: reference clock in, delay code out of one phase-shift reference circuit
`timescale 1ns/1ps
interface ddq_phase_if;
  import ddq_pkg::*;
  logic ref_in;
  logic [CODE_W-1:0] code;
  logic code_ok;
  modport src (output ref_in, input code, input code_ok);
  modport circ (input ref_in, output code, output code_ok);
endinterface

// >>> logic/ddq_phase_ref.sv
// phase-shift reference circuit: measures the reference period, emits a quarter-period code
`timescale 1ns/1ps
module ddq_phase_ref (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  ddq_phase_if.circ pif
);
  import ddq_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    ddq_phase_st_t st;
    logic [CNT_W-1:0] cnt;
    logic [CODE_W-1:0] code;
    logic ok;
  } ddq_phase_state_t;

  ddq_phase_state_t p_r;
  ddq_phase_state_t p_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    p_nxt = p_r;
    if (ce) begin
      p_nxt.s1 = pif.ref_in;
      p_nxt.s2 = p_r.s1;
      p_nxt.s3 = p_r.s2;
      if (p_r.cnt != CNT_MAX) begin
        p_nxt.cnt = p_r.cnt + CNT_ONE;
      end
      if (p_r.s2 && !p_r.s3) begin
        p_nxt.cnt = CNT_ONE;
        case (p_r.st)
          DDQ_SEEK: begin
            p_nxt.st = DDQ_MEAS;
          end
          DDQ_MEAS: begin
            // quarter period centres the strobe in the data window
            p_nxt.code = p_r.cnt[CNT_W-1:2];
            p_nxt.ok = 1'b1;
          end
          default: begin
            p_nxt.st = DDQ_SEEK;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      p_r <= '{st: DDQ_SEEK, default: '0};
    end else begin
      p_r <= p_nxt;
    end
  end

  assign pif.code = p_r.code;
  assign pif.code_ok = p_r.ok;

endmodule

// >>> logic/ddq_io_datapath.sv
// top: double-rate pin datapath with strobe capture and top/bottom delay reference
`timescale 1ns/1ps
module ddq_io_datapath (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic strobe_clk,
  input wire ddq_pkg::ddq_width_t bus_mode,
  input wire logic parity_lanes,
  input wire logic bidir_mode,
  input wire logic [ddq_pkg::DQ_W-1:0] wr_first,
  input wire logic [ddq_pkg::DQ_W-1:0] wr_second,
  input wire logic wr_oe_b,
  input wire logic [ddq_pkg::DQ_W-1:0] dq_in,
  output logic [ddq_pkg::DQ_W-1:0] dq_out,
  output logic [ddq_pkg::DQ_W-1:0] dq_oe,
  output logic [ddq_pkg::DQ_W-1:0] rd_first,
  output logic [ddq_pkg::DQ_W-1:0] rd_second,
  output logic rd_valid,
  input wire logic top_ref_pin,
  input wire logic top_pll_ref,
  input wire logic top_use_pll,
  input wire logic bot_ref_pin,
  input wire logic bot_pll_ref,
  input wire logic bot_use_pll,
  input wire logic grp_on_bottom,
  output logic [ddq_pkg::EDGE_STROBES-1:0][ddq_pkg::CODE_W-1:0] dly_top,
  output logic [ddq_pkg::EDGE_STROBES-1:0][ddq_pkg::CODE_W-1:0] dly_bot,
  output logic [ddq_pkg::CODE_W-1:0] grp_dly,
  output logic grp_dly_ok
);
  import ddq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // state types

  typedef struct packed {
    logic ce_q;
    ddq_width_t width;
    logic par;
    logic bidir;
    logic bot;
    logic [DQ_W-1:0] out_a;
    logic [DQ_W-1:0] out_b;
    logic [DQ_W-1:0] oe_b;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic ack;
    logic [DQ_W-1:0] rd_a;
    logic [DQ_W-1:0] rd_b;
    logic rd_v;
    logic [EDGE_STROBES-1:0][CODE_W-1:0] dly_t;
    logic [EDGE_STROBES-1:0][CODE_W-1:0] dly_b;
    logic [CODE_W-1:0] grp;
    logic grp_ok;
  } ddq_ref_t;

  typedef struct packed {
    logic [DQ_W-1:0] oe_b;
  } ddq_fall_t;

  typedef struct packed {
    logic ce_s1;
    logic ce_s2;
    logic [2:0] w_s1;
    logic [2:0] w_s2;
    logic ack_s1;
    logic ack_s2;
    logic [DQ_W-1:0] cap_a;
    logic a_ok;
    logic [DQ_W-1:0] word_a;
    logic [DQ_W-1:0] word_b;
    logic req;
  } ddq_stb_t;

  typedef struct packed {
    logic [DQ_W-1:0] cap_b;
  } ddq_stb_fall_t;

  ddq_ref_t r_r;
  ddq_ref_t r_nxt;
  ddq_fall_t f_r;
  ddq_fall_t f_nxt;
  ddq_stb_t s_r;
  ddq_stb_t s_nxt;
  ddq_stb_fall_t sf_r;
  ddq_stb_fall_t sf_nxt;

  logic [DQ_W-1:0] out_lanes;
  logic [DQ_W-1:0] cap_lanes;

  ////////////////////////////////////////////////////////////////////////////////
  // phase-shift reference circuits, one per edge

  ddq_phase_if top_if ();
  ddq_phase_if bot_if ();

  assign top_if.ref_in = top_use_pll ? top_pll_ref : top_ref_pin;
  assign bot_if.ref_in = bot_use_pll ? bot_pll_ref : bot_ref_pin;

  ddq_phase_ref u_top_ref (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ce(ce),
    .pif(top_if.circ)
  );

  ddq_phase_ref u_bot_ref (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ce(ce),
    .pif(bot_if.circ)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // fabric clock domain: output registers, enables, capture hand-off, delay codes

  assign out_lanes = ddq_lanes(r_r.width, r_r.par);

  always_comb begin
    r_nxt = r_r;
    r_nxt.ce_q = ce;
    if (ce) begin
      r_nxt.width = bus_mode;
      r_nxt.par = parity_lanes;
      r_nxt.bidir = bidir_mode;
      r_nxt.bot = grp_on_bottom;
      r_nxt.out_a = wr_first & out_lanes;
      r_nxt.out_b = wr_second & out_lanes;
      r_nxt.oe_b = ~out_lanes | {DQ_W{wr_oe_b}};
      r_nxt.req_s1 = s_r.req;
      r_nxt.req_s2 = r_r.req_s1;
      r_nxt.req_s3 = r_r.req_s2;
      r_nxt.rd_v = 1'b0;
      if (r_r.req_s2 != r_r.req_s3) begin
        // strobe side holds the word stable until this acknowledge returns
        r_nxt.rd_a = s_r.word_a & out_lanes;
        r_nxt.rd_b = s_r.word_b & out_lanes;
        r_nxt.rd_v = 1'b1;
        r_nxt.ack = r_r.req_s2;
      end
      for (int i = 0; i < EDGE_STROBES; i++) begin
        r_nxt.dly_t[i] = top_if.code;
        r_nxt.dly_b[i] = bot_if.code;
      end
      r_nxt.grp = r_r.bot ? bot_if.code : top_if.code;
      r_nxt.grp_ok = r_r.bot ? bot_if.code_ok : top_if.code_ok;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_r <= '{oe_b: '1, width: DDQ_X4, default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

  // falling-edge enable register for bidirectional turnaround
  always_comb begin
    f_nxt = f_r;
    if (ce) begin
      f_nxt.oe_b = r_r.oe_b;
    end
  end

  always_ff @(negedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      f_r <= '{oe_b: '1};
    end else begin
      f_r <= f_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin side: clock level selects the bit, enables active low inside

  assign dq_out = ref_clk ? r_r.out_a : r_r.out_b;

  always_comb begin
    if (r_r.bidir) begin
      // driver turns on only after the falling edge, off at the rising edge
      dq_oe = ~(r_r.oe_b | f_r.oe_b);
    end else begin
      dq_oe = ~r_r.oe_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // strobe clock domain: delayed strobe clocks the group's capture registers

  assign cap_lanes = ddq_lanes(ddq_width_t'(s_r.w_s2[2:1]), s_r.w_s2[0]);

  always_comb begin
    s_nxt = s_r;
    s_nxt.ce_s1 = r_r.ce_q;
    s_nxt.ce_s2 = s_r.ce_s1;
    s_nxt.w_s1 = {r_r.width, r_r.par};
    s_nxt.w_s2 = s_r.w_s1;
    s_nxt.ack_s1 = r_r.ack;
    s_nxt.ack_s2 = s_r.ack_s1;
    if (s_r.ce_s2) begin
      s_nxt.cap_a = dq_in;
      s_nxt.a_ok = 1'b1;
      if (s_r.a_ok && (s_r.req == s_r.ack_s2)) begin
        // pair from last rising and falling edges, offered on this rising edge
        s_nxt.word_a = s_r.cap_a & cap_lanes;
        s_nxt.word_b = sf_r.cap_b & cap_lanes;
        s_nxt.req = ~s_r.req;
      end
    end
  end

  always_ff @(posedge strobe_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    sf_nxt = sf_r;
    if (s_r.ce_s2) begin
      sf_nxt.cap_b = dq_in;
    end
  end

  always_ff @(negedge strobe_clk or negedge rst_b) begin
    if (!rst_b) begin
      sf_r <= '0;
    end else begin
      sf_r <= sf_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registered outputs

  assign rd_first = r_r.rd_a;
  assign rd_second = r_r.rd_b;
  assign rd_valid = r_r.rd_v;
  assign dly_top = r_r.dly_t;
  assign dly_bot = r_r.dly_b;
  assign grp_dly = r_r.grp;
  assign grp_dly_ok = r_r.grp_ok;

endmodule

// >>> tb/ddq_io_monitor.sv
// checker: port relations of the double-rate datapath
`timescale 1ns/1ps
module ddq_io_monitor
  import ddq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire ddq_pkg::ddq_width_t bus_mode,
  input wire logic bidir_mode,
  input wire logic [ddq_pkg::DQ_W-1:0] wr_first,
  input wire logic [ddq_pkg::DQ_W-1:0] wr_second,
  input wire logic wr_oe_b,
  input wire logic [ddq_pkg::DQ_W-1:0] dq_out,
  input wire logic [ddq_pkg::DQ_W-1:0] dq_oe,
  input wire logic [ddq_pkg::DQ_W-1:0] rd_first,
  input wire logic [ddq_pkg::DQ_W-1:0] rd_second,
  input wire logic rd_valid,
  input wire logic grp_on_bottom,
  input wire logic [ddq_pkg::EDGE_STROBES-1:0][ddq_pkg::CODE_W-1:0] dly_top,
  input wire logic [ddq_pkg::EDGE_STROBES-1:0][ddq_pkg::CODE_W-1:0] dly_bot,
  input wire logic [ddq_pkg::CODE_W-1:0] grp_dly,
  input wire logic grp_dly_ok
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_pulse;
    rd_valid ##1 !rd_valid [*2];
  endsequence
  a_low_second:
  assert property ($past(rst_b) && $past(ce) |-> dq_out[0] == $past(wr_second[0]))
    else $error("low phase bit wrong");
  a_high_first:
  assert property (@(negedge ref_clk) $past(rst_b) && $past(ce) |-> dq_out[0] == $past(wr_first[0]))
    else $error("high phase bit wrong");
  a_oe_active_low:
  assert property ($past(rst_b) && $past(ce) |-> dq_oe[0] == !$past(wr_oe_b))
    else $error("driver enable wrong");
  a_oe_falling_gate:
  assert property (@(negedge ref_clk) $past(rst_b, 2) && $past(ce) && $past(ce, 2)
    && $past(bidir_mode) && $past(bidir_mode, 2)
    |-> dq_oe[0] == (!$past(wr_oe_b) && !$past(wr_oe_b, 2)))
    else $error("enable not held off to falling edge");
  a_lane_mask:
  assert property (bus_mode == DDQ_X4 && $past(bus_mode) == DDQ_X4
    && $past(bus_mode, 2) == DDQ_X4 && $past(ce) && $past(ce, 2)
    |-> dq_oe[DQ_W-1:4] == '0 && dq_out[DQ_W-1:4] == '0)
    else $error("lane outside width active");
  a_valid_pulse:
  assert property (rd_valid |-> s_pulse)
    else $error("valid pulse too long");
  a_rd_hold:
  assert property ($changed(rd_first) || $changed(rd_second) |-> rd_valid)
    else $error("read pair changed without valid");
  a_grp_select:
  assert property (grp_dly_ok && $stable(grp_on_bottom) && $past(grp_on_bottom, 2) == grp_on_bottom
    |-> grp_dly == (grp_on_bottom ? dly_bot[0] : dly_top[0]))
    else $error("group code from wrong edge");
  a_edge_shared:
  assert property (dly_top == {EDGE_STROBES{dly_top[0]}} && dly_bot == {EDGE_STROBES{dly_bot[0]}})
    else $error("edge codes differ");
endmodule

bind ddq_io_datapath ddq_io_monitor i_mon (.ref_clk, .rst_b, .ce, .bus_mode, .bidir_mode,
  .wr_first, .wr_second, .wr_oe_b, .dq_out, .dq_oe, .rd_first, .rd_second, .rd_valid,
  .grp_on_bottom, .dly_top, .dly_bot, .grp_dly, .grp_dly_ok);

// >>> tb/ddq_mem_model.sv
// partner: memory driving the strobe and data lanes in bursts
`timescale 1ns/1ps
module ddq_mem_model
  import ddq_pkg::*;
(
  input wire logic run,
  input wire logic [DQ_W-1:0] d_a,
  input wire logic [DQ_W-1:0] d_b,
  input wire logic [DQ_W-1:0] dq_out,
  input wire logic [DQ_W-1:0] dq_oe,
  output logic strobe_clk,
  output logic [DQ_W-1:0] dq_in
);
  logic [DQ_W-1:0] q;
  // pin level: device drive wins over memory lanes
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & q);
  initial begin
    strobe_clk = 1'h0;
    q = '0;
    #0.7;
    forever begin
      if (run) begin
        q = d_a;
        #1.5 strobe_clk = 1'h1;
        #1.5 q = d_b;
        #1.5 strobe_clk = 1'h0;
        #1.5;
      end else begin
        q = ~q;
        #3;
      end
    end
  end
endmodule

// >>> tb/ddq_io_datapath_tb.sv
// bench: directed checks of the double-rate datapath
`timescale 1ns/1ps
module ddq_io_datapath_tb;
  import ddq_pkg::*;
  typedef struct packed {ddq_width_t m; logic p; logic [DQ_W-1:0] l;} ddq_row_t;
  logic ref_clk, rst_b, ce, strobe_clk, parity_lanes, bidir_mode, wr_oe_b, rd_valid, run;
  logic top_ref_pin, top_pll_ref, bot_ref_pin, bot_pll_ref, grp_on_bottom, grp_dly_ok;
  logic top_use_pll, bot_use_pll;
  ddq_width_t bus_mode;
  logic [DQ_W-1:0] wr_first, wr_second, dq_in, dq_out, dq_oe, rd_first, rd_second;
  logic [EDGE_STROBES-1:0][CODE_W-1:0] dly_top, dly_bot;
  logic [CODE_W-1:0] grp_dly;
  logic [5:0] ct = 6'h0;
  logic [5:0] cb = 6'h0;
  int error_cnt, tests_run, i, n;
  ddq_row_t rows [8] = '{'{DDQ_X4, 1'h0, LANES_X4}, '{DDQ_X4, 1'h1, LANES_X4},
    '{DDQ_X8, 1'h0, LANES_X8}, '{DDQ_X8, 1'h1, LANES_X9}, '{DDQ_X16, 1'h0, LANES_X16},
    '{DDQ_X16, 1'h1, LANES_X18}, '{DDQ_X32, 1'h0, LANES_X32}, '{DDQ_X32, 1'h1, LANES_X36}};
  ddq_io_datapath i_dut (.ref_clk, .rst_b, .ce, .strobe_clk, .bus_mode, .parity_lanes,
    .bidir_mode, .wr_first, .wr_second, .wr_oe_b, .dq_in, .dq_out, .dq_oe, .rd_first,
    .rd_second, .rd_valid, .top_ref_pin, .top_pll_ref, .top_use_pll, .bot_ref_pin,
    .bot_pll_ref, .bot_use_pll, .grp_on_bottom, .dly_top, .dly_bot, .grp_dly,
    .grp_dly_ok);
  ddq_mem_model i_mem (.run, .d_a(36'h5_5555_5555), .d_b(36'ha_aaaa_aaaa), .dq_out, .dq_oe,
    .strobe_clk, .dq_in);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end
  // strobe-rate references: top pin 40, top pll 8, bottom pin 16, bottom pll 64
  always @(posedge ref_clk) begin
    ct <= (ct == 6'h27) ? 6'h0 : ct + 6'h1;
    cb <= cb + 6'h1;
    top_ref_pin <= ct < 6'h14;
    top_pll_ref <= cb[2];
    bot_ref_pin <= cb[3];
    bot_pll_ref <= cb[5];
  end
  task automatic chk(input logic [DQ_W-1:0] seen, input logic [DQ_W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wv();
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (rd_valid !== 1'h1 && n < 300);
    if (n >= 300) begin
      error_cnt++;
      $display("[FAIL] %0t read pair wait timed out", $time);
      finish_test();
    end
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    rst_b <= 1'h0;
    run = 1'h1;
    repeat (20) @(posedge ref_clk);
    #1;
    chk(dq_oe | dq_out | rd_first | rd_second, 36'h0);
    chk({10'h0, dly_top[0], dly_bot[0], grp_dly, rd_valid, grp_dly_ok}, 36'h0);
    run = 1'h0;
    @(posedge ref_clk);
    rst_b <= 1'h1;
    $display("reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b, run, parity_lanes, bidir_mode, grp_on_bottom} = '0;
    {top_use_pll, bot_use_pll} = 2'h1;
    {ce, wr_oe_b} = 2'h3;
    bus_mode = DDQ_X4;
    wr_first = 36'h9_6969_6969;
    wr_second = 36'h6_9696_9696;
    do_reset();
    for (i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      bus_mode <= rows[i].m;
      parity_lanes <= rows[i].p;
      wr_oe_b <= 1'h0;
      repeat (2) @(posedge ref_clk);
      #25 chk(dq_out, wr_first & rows[i].l);
      #50 chk(dq_out, wr_second & rows[i].l);
      chk(dq_oe, rows[i].l);
      @(posedge ref_clk);
      wr_oe_b <= 1'h1;
      repeat (2) @(posedge ref_clk);
      run = 1'h1;
      wv();
      wv();
      chk(rd_first, 36'h5_5555_5555 & rows[i].l);
      chk(rd_second, 36'ha_aaaa_aaaa & rows[i].l);
      run = 1'h0;
      $display("row %0d done", i);
    end
    @(posedge ref_clk);
    bidir_mode <= 1'h1;
    repeat (2) @(posedge ref_clk);
    wr_oe_b <= 1'h0;
    @(posedge ref_clk);
    #25 chk(dq_oe, 36'h0);
    #50 chk(dq_oe, LANES_X36);
    @(posedge ref_clk);
    wr_oe_b <= 1'h1;
    #25 chk(dq_oe, LANES_X36);
    @(posedge ref_clk);
    #25 chk(dq_oe, 36'h0);
    run = 1'h1;
    wv();
    wv();
    chk(rd_first, 36'h5_5555_5555);
    run = 1'h0;
    $display("bidirectional done");
    @(posedge ref_clk);
    ce <= 1'h0;
    wr_first <= 36'h0;
    repeat (2) @(posedge ref_clk);
    #25 chk(dq_out, 36'h9_6969_6969);
    @(posedge ref_clk);
    ce <= 1'h1;
    $display("clock enable done");
    n = 0;
    while (grp_dly_ok !== 1'h1 && n < 300) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 300) begin
      error_cnt++;
      $display("[FAIL] %0t delay code wait timed out", $time);
      finish_test();
    end
    for (i = 0; i < EDGE_STROBES; i++) begin
      chk({28'h0, dly_top[i]}, 36'h0a);
      chk({28'h0, dly_bot[i]}, 36'h10);
    end
    chk({28'h0, grp_dly}, 36'h0a);
    @(posedge ref_clk);
    grp_on_bottom <= 1'h1;
    repeat (3) @(posedge ref_clk);
    #1 chk({28'h0, grp_dly}, 36'h10);
    $display("delay reference done");
    @(posedge ref_clk);
    top_use_pll <= 1'h1;
    bot_use_pll <= 1'h0;
    repeat (48) @(posedge ref_clk);
    #1 chk({28'h0, dly_top[0]}, 36'h02);
    chk({28'h0, dly_bot[0]}, 36'h04);
    chk({28'h0, grp_dly}, 36'h04);
    $display("reference source done");
    do_reset();
    repeat (2) @(posedge ref_clk);
    #1 chk({34'h0, rd_valid, grp_dly_ok}, 36'h0);
    chk(dq_oe, 36'h0);
    $display("second reset done");
    finish_test();
  end
endmodule
